// *** pkg/wind_limit_pkg.sv ***
// Constants, types and tables shared by the wind speed limit channel
package wind_limit_pkg;

	// ----------------------------------------------------------------
	// Clock and time base
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 250_000_000;
	localparam int unsigned TICK_TIME_S  = 1;
	localparam int unsigned SEC_CYCLES   = TICK_TIME_S * CLK_HZ;
	localparam int unsigned CYC_UNIT_S   = 10;
	localparam int unsigned CYC_MAX      = 120;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFS   = 4'h0;
	localparam logic [3:0] THR_OFFS    = 4'h4;
	localparam logic [3:0] STATUS_OFFS = 4'h8;
	localparam logic [3:0] SPEED_OFFS  = 4'hc;

	// Control register fields
	localparam int HYST_LSB    = 0;
	localparam int MODE_LSB    = 4;
	localparam int SRC_LSB     = 8;
	localparam int ON_DLY_LSB  = 12;
	localparam int OFF_DLY_LSB = 16;
	localparam int SOC_BIT     = 20;
	localparam logic [31:0] CTRL_MASK  = 32'h001f_f3f7;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Threshold register fields
	localparam int THR_SEL_LSB = 0;
	localparam int CYC_LSB     = 8;
	localparam logic [31:0] THR_MASK   = 32'h0000_7f0f;
	localparam logic [31:0] THR_RESET  = 32'h0000_0007;

	// Status register fields
	localparam int ST_OBJ_BIT  = 0;
	localparam int ST_RAW_BIT  = 1;
	localparam int ST_EXT_BIT  = 2;
	localparam int ST_RUN_BIT  = 3;
	localparam int ST_THR_LSB  = 16;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SRC_NONE, SRC_EXT16, SRC_EXT8, SRC_TEACH} src_e;
	typedef enum logic [1:0] {ACT_NONE, ACT_ON, ACT_OFF} act_e;

	typedef struct packed {
		logic falling;
		act_e trig_act;
		act_e rel_act;
	} mode_s;

	typedef struct packed {
		logic        ext16_valid;
		logic [15:0] ext16_data;
		logic        ext8_valid;
		logic [7:0]  ext8_data;
		logic        teach_store;
	} ext_s;

	typedef struct packed {
		logic valid;
		logic value;
	} tx_s;

	// Threshold steps in m/s, hysteresis steps in m/s, delays in seconds
	localparam logic [15:0] THR_TABLE [12] = '{16'h0001, 16'h0003, 16'h0005,
		16'h0008, 16'h000a, 16'h000c, 16'h000f, 16'h0014, 16'h0016, 16'h0019,
		16'h001e, 16'h0023};
	localparam logic [15:0] HYST_TABLE [5] = '{16'h0001, 16'h0003, 16'h0005,
		16'h0008, 16'h000a};
	localparam logic [11:0] DLY_TABLE [14] = '{12'h000, 12'h001, 12'h003,
		12'h005, 12'h00a, 12'h00f, 12'h01e, 12'h03c, 12'h0b4, 12'h12c,
		12'h258, 12'h384, 12'h708, 12'he10};

endpackage : wind_limit_pkg

// *** design/wind_speed_limit_comparator.sv ***
// Wind speed limit channel with AXI4-Lite port
//
// What this block does
// RQ1: Hysteresis 1, 3, 5, 8 or 10 m/s.
// RQ2: Rising pair: over threshold, back under it minus hysteresis.
// RQ3: Falling pair: under threshold, back over it plus hysteresis.
// RQ4: A no-telegram crossing emits nothing.
// RQ5: Twelve modes; a crossing gives ON or OFF.
// RQ6: Act only on crossings in the mode's direction.
// RQ7: Source none uses the configured threshold.
// RQ8: 16-bit external value becomes threshold.
// RQ9: 8-bit external value becomes threshold.
// RQ10: Teach stores present speed as threshold.
// RQ11: Download replaces external threshold.
// RQ12: External used again after a fresh value.
// RQ13: Switch-on delay none, 1..30 s, 1..60 min.
// RQ14: Active state enters after switch-on delay.
// RQ15: Switch-off delay none, 1..30 s, 1..60 min.
// RQ16: Inactive state enters after switch-off delay.
// RQ17: No cyclic send in a no-telegram condition.
// RQ18: Change sending off: no change telegram.
// RQ19: Change sending on: telegram on every change.
// RQ20: Nonzero cyclic setting sends periodically.
// RQ21: Both off: never sent.
// RQ22: Cyclic setting 0 to 120, ten-second units.
// RQ23: Cyclic period is setting times ten s.
// RQ24: Cyclic setting zero stops cyclic sending.
// RQ25: Threshold 1 to 35 m/s in fixed steps.
// RQ26: One-second tick; reset clears timers, object.
module wind_speed_limit_comparator
	import wind_limit_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SEC_CYCLES
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Measurement and external objects from the bus stack
	input  wire logic [15:0] wind_speed,
	input  ext_s             ext_in,
	// Limit object towards the bus stack
	output tx_s              limit_tx,
	output logic             limit_value
);

	// ----------------------------------------------------------------
	// Decoding functions
	// ----------------------------------------------------------------

	// Activation mode to crossing direction and actions
	function automatic mode_s mode_decode(input logic [3:0] m);
		mode_s d;
		d = '{falling: 1'b0, trig_act: ACT_ON, rel_act: ACT_OFF};
		case (m)
			4'h1: d = '{1'b0, ACT_OFF, ACT_ON};
			4'h2: d = '{1'b1, ACT_ON, ACT_OFF};
			4'h3: d = '{1'b1, ACT_OFF, ACT_ON};
			4'h4: d = '{1'b0, ACT_ON, ACT_NONE};
			4'h5: d = '{1'b0, ACT_OFF, ACT_NONE};
			4'h6: d = '{1'b1, ACT_ON, ACT_NONE};
			4'h7: d = '{1'b1, ACT_OFF, ACT_NONE};
			4'h8: d = '{1'b0, ACT_NONE, ACT_OFF};
			4'h9: d = '{1'b0, ACT_NONE, ACT_ON};
			4'ha: d = '{1'b1, ACT_NONE, ACT_OFF};
			4'hb: d = '{1'b1, ACT_NONE, ACT_ON};
			default: d = '{1'b0, ACT_ON, ACT_OFF};
		endcase
		return d;
	endfunction : mode_decode

	// Delay selector to seconds, out of range means no delay
	function automatic logic [11:0] delay_secs(input logic [3:0] sel);
		return (sel < 4'he) ? DLY_TABLE[sel] : DLY_TABLE[0];
	endfunction : delay_secs

	// Merge write data into a register under the byte strobes
	function automatic logic [31:0] strobe_merge(input logic [31:0] old,
			input logic [31:0] data, input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r & mask;
	endfunction : strobe_merge

	// ----------------------------------------------------------------
	// Register storage and internal state
	// ----------------------------------------------------------------
	logic [31:0] ctrl_reg;
	logic [31:0] thr_reg;
	logic [31:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        aw_full_reg;
	logic        w_full_reg;
	logic [15:0] ext_thr_reg;
	logic        ext_ok_reg;
	logic        raw_reg;
	logic        target_reg;
	logic        obj_reg;
	logic        run_reg;
	logic [11:0] dly_cnt_reg;
	logic [27:0] tick_cnt_reg;
	logic [10:0] cyc_cnt_reg;

	// ----------------------------------------------------------------
	// Configuration fields
	// ----------------------------------------------------------------
	wire logic [2:0]  hyst_sel  = ctrl_reg[HYST_LSB +: 3];
	wire logic [3:0]  mode_sel  = ctrl_reg[MODE_LSB +: 4];
	wire src_e        src_sel   = src_e'(ctrl_reg[SRC_LSB +: 2]);
	wire logic [3:0]  on_sel    = ctrl_reg[ON_DLY_LSB +: 4];
	wire logic [3:0]  off_sel   = ctrl_reg[OFF_DLY_LSB +: 4];
	wire logic        soc_en    = ctrl_reg[SOC_BIT];
	wire logic [3:0]  thr_sel   = thr_reg[THR_SEL_LSB +: 4];
	wire logic [6:0]  cyc_set   = thr_reg[CYC_LSB +: 7];
	wire mode_s       mode      = mode_decode(mode_sel);

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------

	// Address and data taken apart; write fires once both are in
	assign s_axi_awready = !aw_full_reg;
	assign s_axi_wready  = !w_full_reg;
	assign s_axi_arready = !s_axi_rvalid;

	wire logic       aw_take  = s_axi_awvalid && s_axi_awready;
	wire logic       w_take   = s_axi_wvalid && s_axi_wready;
	wire logic       wr_fire  = aw_full_reg && w_full_reg && !s_axi_bvalid;
	wire logic [3:0] wr_offs  = awaddr_reg[3:0];
	wire logic       wr_hi_ok = awaddr_reg[31:4] == 28'h0000000;
	wire logic       wr_ctrl  = wr_fire && wr_hi_ok && wr_offs == CTRL_OFFS;
	wire logic       wr_thr   = wr_fire && wr_hi_ok && wr_offs == THR_OFFS;
	wire logic       wr_ro    = wr_fire && wr_hi_ok && (wr_offs == STATUS_OFFS
		|| wr_offs == SPEED_OFFS);
	wire logic       wr_ok    = wr_ctrl || wr_thr || wr_ro;
	wire logic       download = wr_ctrl || wr_thr;
	wire logic [31:0] thr_merged = strobe_merge(thr_reg, wdata_reg, wstrb_reg, THR_MASK);

	// Write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg  <= 1'b0;
			w_full_reg   <= 1'b0;
			awaddr_reg   <= 32'h0000_0000;
			wdata_reg    <= 32'h0000_0000;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_full_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (w_take) begin
				w_full_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Configuration registers; threshold step clipped to the offered range
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CTRL_RESET;
			thr_reg  <= THR_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= strobe_merge(ctrl_reg, wdata_reg, wstrb_reg, CTRL_MASK);
			end
			if (wr_thr) begin
				thr_reg <= thr_merged; // [RQ22]
				if (thr_merged[THR_SEL_LSB +: 4] > 4'hb) begin
					thr_reg[THR_SEL_LSB +: 4] <= 4'hb; // [RQ25]
				end
				if (thr_merged[CYC_LSB +: 7] > 7'(CYC_MAX)) begin
					thr_reg[CYC_LSB +: 7] <= 7'(CYC_MAX); // [RQ22]
				end
			end
		end
	end

	// Read decode
	wire logic [3:0]  rd_offs  = s_axi_araddr[3:0];
	wire logic        rd_hi_ok = s_axi_araddr[31:4] == 28'h0000000;
	wire logic [15:0] act_thr;
	logic      [31:0] status_word;
	logic      [31:0] rd_word;
	logic             rd_ok;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ST_OBJ_BIT] = obj_reg;
		status_word[ST_RAW_BIT] = raw_reg;
		status_word[ST_EXT_BIT] = ext_ok_reg;
		status_word[ST_RUN_BIT] = run_reg;
		status_word[ST_THR_LSB +: 16] = act_thr;
		rd_ok   = rd_hi_ok;
		rd_word = 32'h0000_0000;
		case (rd_offs)
			CTRL_OFFS:   rd_word = ctrl_reg;
			THR_OFFS:    rd_word = thr_reg;
			STATUS_OFFS: rd_word = status_word;
			SPEED_OFFS:  rd_word = {16'h0000, wind_speed};
			default:     rd_ok = 1'b0;
		endcase
	end

	// Read data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
			s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Threshold source
	// ----------------------------------------------------------------
	wire logic [15:0] cfg_thr = THR_TABLE[thr_sel];                            // [RQ25]
	wire logic        ext_set = (src_sel == SRC_EXT16 && ext_in.ext16_valid)
		|| (src_sel == SRC_EXT8 && ext_in.ext8_valid)
		|| (src_sel == SRC_TEACH && ext_in.teach_store);
	assign act_thr = (src_sel != SRC_NONE && ext_ok_reg) ? ext_thr_reg : cfg_thr; // [RQ7]

	// External value wins over a download in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_thr_reg <= 16'h0000;
			ext_ok_reg  <= 1'b0;
		end else if (ext_set) begin
			ext_ok_reg <= 1'b1;                                                 // [RQ12]
			case (src_sel)
				SRC_EXT16: ext_thr_reg <= ext_in.ext16_data;                   // [RQ8]
				SRC_EXT8:  ext_thr_reg <= {8'h00, ext_in.ext8_data};           // [RQ9]
				SRC_TEACH: ext_thr_reg <= wind_speed;                          // [RQ10]
				default:   ext_thr_reg <= ext_thr_reg;
			endcase
		end else if (download) begin
			ext_ok_reg <= 1'b0;                                                 // [RQ11]
		end
	end

	// ----------------------------------------------------------------
	// Comparator with hysteresis
	// ----------------------------------------------------------------
	wire logic [15:0] hyst     = HYST_TABLE[(hyst_sel < 3'h5) ? hyst_sel : 3'h0]; // [RQ1]
	wire logic [16:0] upper    = {1'b0, act_thr} + {1'b0, hyst};
	wire logic [15:0] lower    = (act_thr > hyst) ? act_thr - hyst : 16'h0000;
	wire logic        trig_hit = mode.falling ? (wind_speed < act_thr)
		: (wind_speed > act_thr);
	wire logic        rel_hit  = mode.falling ? ({1'b0, wind_speed} > upper)     // [RQ3]
		: (wind_speed < lower);                                                // [RQ2]
	wire logic        trig_evt = !raw_reg && trig_hit;                         // [RQ6]
	wire logic        rel_evt  = raw_reg && rel_hit;                           // [RQ6]
	wire act_e        evt_act  = trig_evt ? mode.trig_act : mode.rel_act;      // [RQ5]

	// Crossing state and requested object value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			raw_reg    <= 1'b0;
			target_reg <= 1'b0;
		end else if (trig_evt || rel_evt) begin
			raw_reg <= trig_evt;
			if (evt_act != ACT_NONE) begin
				target_reg <= (evt_act == ACT_ON);                             // [RQ4]
			end
		end
	end

	// ----------------------------------------------------------------
	// One-second tick
	// ----------------------------------------------------------------
	wire logic sec_tick = tick_cnt_reg == 28'(TICK_CYCLES - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_reg <= 28'h0000000;                                       // [RQ26]
		end else begin
			tick_cnt_reg <= sec_tick ? 28'h0000000 : tick_cnt_reg + 28'h0000001;
		end
	end

	// ----------------------------------------------------------------
	// Switch-on and switch-off delay
	// ----------------------------------------------------------------
	wire logic [11:0] dly_load = target_reg ? delay_secs(on_sel)              // [RQ13]
		: delay_secs(off_sel);                                                 // [RQ15]
	wire logic        pending  = target_reg != obj_reg;
	wire logic        accept   = pending && ((!run_reg && dly_load == 12'h000)
		|| (run_reg && sec_tick && dly_cnt_reg == 12'h001));

	// Object takes the target once its delay runs out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			obj_reg     <= 1'b0;                                               // [RQ26]
			run_reg     <= 1'b0;
			dly_cnt_reg <= 12'h000;
		end else if (!pending) begin
			run_reg <= 1'b0;
		end else if (accept) begin
			obj_reg <= target_reg;                                             // [RQ14] [RQ16]
			run_reg <= 1'b0;
		end else if (!run_reg) begin
			run_reg     <= 1'b1;
			dly_cnt_reg <= dly_load;
		end else if (sec_tick) begin
			dly_cnt_reg <= dly_cnt_reg - 12'h001;
		end
	end

	// ----------------------------------------------------------------
	// Transmission scheduling
	// ----------------------------------------------------------------
	wire logic [10:0] cyc_period = 11'(cyc_set) * 11'(CYC_UNIT_S);            // [RQ23]
	wire logic        cyc_due    = cyc_set != 7'h00 && sec_tick               // [RQ24]
		&& cyc_cnt_reg >= cyc_period - 11'h001;
	wire logic        suppress   = raw_reg ? (mode.trig_act == ACT_NONE)
		: (mode.rel_act == ACT_NONE);
	wire logic        chg_send   = soc_en && accept;                           // [RQ18] [RQ19]
	wire logic        cyc_send   = cyc_due && !suppress;                       // [RQ17] [RQ20]

	// Seconds since last cyclic slot
	always_ff @(posedge aclk) begin
		if (!aresetn || cyc_set == 7'h00) begin
			cyc_cnt_reg <= 11'h000;
		end else if (sec_tick) begin
			cyc_cnt_reg <= cyc_due ? 11'h000 : cyc_cnt_reg + 11'h001;
		end
	end

	// Telegram strobe from change or cyclic path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			limit_tx <= '{valid: 1'b0, value: 1'b0};
		end else begin
			limit_tx.valid <= chg_send || cyc_send;                            // [RQ21]
			limit_tx.value <= accept ? target_reg : obj_reg;
		end
	end

	assign limit_value = obj_reg;

endmodule : wind_speed_limit_comparator

// *** verif/wind_limit_asserts.sv ***
// Assertions for the wind speed limit channel
module wind_limit_asserts
	import wind_limit_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SEC_CYCLES
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Register bus
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Limit object
	input  tx_s              limit_tx,
	input  wire logic        limit_value
);
	// ----------------------------------------------------------------
	// Helper logic and sequences
	// ----------------------------------------------------------------
	logic bad_reg;

	// Pending write address unmapped
	always_ff @(posedge aclk) begin
		if (!aresetn)
			bad_reg <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready)
			bad_reg <= (s_axi_awaddr[31:4] != 28'h0) || (s_axi_awaddr[1:0] != 2'h0);
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_take_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take_s;
		s_axi_arvalid && s_axi_arready;
	endsequence

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	aw_lock_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready high");
	w_lock_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("wready high");
	wr_resp_a: assert property (wr_take_s |-> ##2 s_axi_bvalid)
		else $error("bvalid late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bvalid dropped");
	b_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == (bad_reg ? RESP_SLVERR : RESP_OKAY))
		else $error("bad bresp");
	rd_resp_a: assert property (rd_take_s |=> s_axi_rvalid && !s_axi_arready)
		else $error("rvalid late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rdata dropped");
	tx_value_a: assert property (limit_tx.valid |-> limit_tx.value == limit_value)
		else $error("telegram value");
	rst_clear_a: assert property ($rose(aresetn) |-> !limit_value && !limit_tx.valid && !s_axi_bvalid)
		else $error("not cleared");

endmodule : wind_limit_asserts

bind wind_speed_limit_comparator wind_limit_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .limit_tx(limit_tx), .limit_value(limit_value)
);

// *** verif/bus_stack_model.sv ***
// Bus stack stand-in for the limit channel
module bus_stack_model
	import wind_limit_pkg::*;
(
	// Clock
	input  wire logic   aclk,
	// Towards the channel
	output logic [15:0] wind_speed,
	output ext_s        ext_in,
	// From the channel
	input  tx_s         limit_tx
);
	timeunit 1ns;
	timeprecision 1ps;

	logic got_q [$];

	// Quiet lines at time zero
	initial begin
		wind_speed = 16'h0;
		ext_in = '0;
	end

	// Log telegrams mid-cycle
	always @(negedge aclk) begin
		if (limit_tx.valid === 1'b1)
			got_q.push_back(limit_tx.value);
	end

	// New measured speed
	task automatic set_speed(input logic [15:0] v);
		@(posedge aclk);
		wind_speed <= v;
	endtask : set_speed

	// One-cycle object pulse: 0 two-byte value, 1 one-byte value, 2 store command
	task automatic pulse(input int kind, input logic [15:0] v);
		@(posedge aclk);
		ext_in.ext16_data <= v;
		ext_in.ext8_data <= v[7:0];
		ext_in.ext16_valid <= (kind == 0);
		ext_in.ext8_valid <= (kind == 1);
		ext_in.teach_store <= (kind == 2);
		@(posedge aclk);
		ext_in <= '{1'b0, ~v, 1'b0, ~v[7:0], 1'b0};
	endtask : pulse

endmodule : bus_stack_model

// *** verif/wind_speed_limit_comparator_test.sv ***
// Self-checking bench for the wind speed limit channel
module wind_speed_limit_comparator_test
	import wind_limit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TICK = 20;
	localparam int THR  = 20;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, limit_value;
	logic [31:0] awaddr, wdata, araddr, rdata, rd, wv;
	logic [1:0]  bresp, rresp, resp;
	logic [2:0]  prot;
	logic [3:0]  strb;
	logic [15:0] wind_speed;
	ext_s        ext_in;
	tx_s         limit_tx;
	int          miscompares, checks_done, h, s, soc, obj, v;
	logic        exp_q [$];
	int          hyst_m [5] = '{1, 3, 5, 8, 10};

	wind_speed_limit_comparator #(.TICK_CYCLES(TICK)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(prot),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(prot), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .wind_speed(wind_speed),
		.ext_in(ext_in), .limit_tx(limit_tx), .limit_value(limit_value)
	);
	bus_stack_model p (.aclk(aclk), .wind_speed(wind_speed), .ext_in(ext_in), .limit_tx(limit_tx));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	// Write, each channel released when taken
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_t, w_t, b_t;
		@(posedge aclk);
		{awaddr, wdata} <= {a, d};
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			r = bresp;
			@(posedge aclk);
			if (aw_t)
				awvalid <= 1'b0;
			if (w_t)
				wvalid <= 1'b0;
		end while (!b_t);
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_t, r_t;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(negedge aclk);
			ar_t = arvalid && arready;
			r_t = rvalid;
			{d, r} = {rdata, rresp};
			@(posedge aclk);
			if (ar_t)
				arvalid <= 1'b0;
		end while (!r_t);
		rready <= 1'b0;
	endtask : axi_rd

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		{obj, h} = '0;
	endtask : do_reset

	// Reset and load config
	task automatic setup(input int ctrl, input int thr);
		p.set_speed(16'(THR));
		do_reset();
		axi_wr(32'(CTRL_OFFS), 32'(ctrl), resp);
		axi_wr(32'(THR_OFFS), 32'(thr), resp);
		p.got_q.delete();
		exp_q.delete();
	endtask : setup

	task automatic cmp_tx();
		check(32'(p.got_q.size()), 32'(exp_q.size()));
		foreach (exp_q[i])
			if (i < p.got_q.size())
				check(32'(p.got_q[i]), 32'(exp_q[i]));
	endtask : cmp_tx

	task automatic wait_chk(input int n, input int e);
		repeat (n) @(posedge aclk);
		check(32'(limit_value), 32'(e));
	endtask : wait_chk

	// New speed, then object and log check
	task automatic step(input int sp, input int act);
		p.set_speed(16'(sp));
		if (act >= 0 && act != obj && soc != 0)
			exp_q.push_back(act[0]);
		if (act >= 0)
			obj = act;
		wait_chk(8, obj);
		cmp_tx();
	endtask : step

	task automatic rd_thr(input int e);
		axi_rd(32'(STATUS_OFFS), rd, resp);
		check(32'(rd[31:16]), 32'(e));
	endtask : rd_thr

	// Clock and watchdog
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{awaddr, wdata, araddr} = '0;
		{awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
		void'($urandom(32'h2b9c));
		{prot, strb} = {3'($urandom()), 4'hf};
		do_reset();
		axi_rd(32'(CTRL_OFFS), rd, resp);
		check(rd, CTRL_RESET);
		axi_rd(32'(THR_OFFS), rd, resp);
		check(rd, THR_RESET);
		axi_wr(32'(THR_OFFS), 32'hffff_ffff, resp);
		axi_rd(32'(THR_OFFS), rd, resp);
		check(rd, 32'h0000_780b);
		wv = $urandom();
		axi_wr(32'(CTRL_OFFS), wv, resp);
		axi_rd(32'(CTRL_OFFS), rd, resp);
		check(rd, wv & CTRL_MASK);
		axi_wr(32'h0000_0010, wv, resp);
		check(32'(resp), 32'(RESP_SLVERR));
		axi_rd(32'h0000_0011, rd, resp);
		check({rd[29:0], resp}, {30'h0, RESP_SLVERR});
		v = $urandom_range(1, 40);
		p.set_speed(16'(v));
		axi_rd(32'(SPEED_OFFS), rd, resp);
		check(rd, 32'(v));
		$display("Register test done");
		for (int m = 0; m < 12; m++) begin
			soc = int'(m % 3 != 2);
			setup((soc << SOC_BIT) | (m << MODE_LSB) | (m % 5), 7);
			h = hyst_m[m % 5];
			s = m[1] ? -1 : 1;
			step(THR + s, (m < 8) ? int'(!m[0]) : -1);
			step(THR - s * h, -1);
			step(THR - s * (h + 1), (m < 4 || m >= 8) ? int'(m[0]) : -1);
		end
		$display("Activation mode test done");
		setup(0, 7);
		p.pulse(0, 16'h0005);
		rd_thr(THR);
		setup(1 << SRC_LSB, 7);
		v = $urandom_range(1, 200);
		p.pulse(0, 16'(v));
		rd_thr(v);
		p.pulse(1, 16'h0003);
		rd_thr(v);
		axi_wr(32'(THR_OFFS), 32'h7, resp);
		rd_thr(THR);
		v = $urandom_range(1, 200);
		p.pulse(0, 16'(v));
		rd_thr(v);
		setup(2 << SRC_LSB, 7);
		v = $urandom_range(0, 255);
		p.pulse(1, 16'(v));
		rd_thr(v);
		setup(3 << SRC_LSB, 7);
		v = $urandom_range(1, 35);
		p.set_speed(16'(v));
		p.pulse(2, 16'h0);
		rd_thr(v);
		$display("External threshold test done");
		setup((1 << SOC_BIT) | (2 << ON_DLY_LSB) | (3 << OFF_DLY_LSB), 7);
		p.set_speed(16'(THR + 1));
		wait_chk(30, 0);
		wait_chk(70, 1);
		exp_q.push_back(1'b1);
		p.set_speed(16'h0);
		wait_chk(60, 1);
		wait_chk(90, 0);
		exp_q.push_back(1'b0);
		cmp_tx();
		setup(4 << MODE_LSB, (1 << CYC_LSB) | 7);
		p.set_speed(16'(THR + 1));
		repeat (1000) @(posedge aclk);
		check(32'(p.got_q.size() inside {[4:6]}), 32'h1);
		check(32'(p.got_q.sum() with (int'(item))), 32'(p.got_q.size()));
		p.set_speed(16'h0);
		repeat (4) @(posedge aclk);
		p.got_q.delete();
		repeat (1000) @(posedge aclk);
		check(32'(p.got_q.size()), 32'h0);
		$display("Delay and cyclic test done");
		final_report();
	end

endmodule : wind_speed_limit_comparator_test
